// ---- hw/sr_pkg.sv ----
// Constants, timing counts and state encoding for the self refresh block
package sr_pkg;
  localparam int CLK_MHZ              = 100;
  localparam int CLK_PERIOD_NS        = 10;
  // Least times, rounded up to whole cycles
  localparam int MIN_SR_RESIDENCY_NS  = 15;
  localparam int MIN_SR_RESIDENCY_CYC =
    (MIN_SR_RESIDENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SR_EXIT_INTERVAL_NS  = 100;
  localparam int SR_EXIT_INTERVAL_CYC =
    (SR_EXIT_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Internal refresh spacing: window over count, rounded down
  localparam int REFRESH_WINDOW_MS    = 32;
  localparam int REFRESH_COUNT        = 4096;
  localparam int REFRESH_INTERVAL_CYC =
    (REFRESH_WINDOW_MS * CLK_MHZ * 1000) / REFRESH_COUNT;
  localparam int TIMER_W              = 12;
  localparam int NUM_BANKS            = 4;
  // Command/address field positions and patterns
  localparam int CA_W                 = 10;
  localparam logic [2:0] SR_ENTRY_CA  = 3'h4;
  localparam logic [3:0] MRW_CA       = 4'h0;
  localparam int MA_LO_POS            = 4;
  localparam int MA_HI_POS            = 0;
  localparam int OP_POS               = 2;
  // Mode register addresses and reset values
  localparam logic [7:0] MR_ADDR_BANK_MASK = 8'h10;
  localparam logic [7:0] MR_ADDR_SEG_MASK  = 8'h11;
  localparam logic [7:0] BANK_MASK_RESET   = 8'h00;
  typedef enum logic [1:0] {
    ST_IDLE     = 2'h0,
    ST_SELF_REF = 2'h1,
    ST_EXIT     = 2'h3
  } sr_state_t;
endpackage : sr_pkg

// ---- hw/sr_timer.sv ----
// Loadable down counter used for refresh spacing and exit timing
`timescale 1ns/1ns
module sr_timer #(
  parameter int W = 12
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic              done
);
  logic [W-1:0] cnt_reg;

  generate
    if (W < 1) begin : g_bad_width
      $error("Timer width must be at least one");
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= load_val;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end

  assign done = (cnt_reg == '0);
endmodule : sr_timer

// ---- hw/dram_refresh_self_refresh.sv ----
// Self refresh entry, residency, exit timing and bank-masked internal refresh
`timescale 1ns/1ns
module dram_refresh_self_refresh #(
  parameter int NUM_BANKS = sr_pkg::NUM_BANKS
) (
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  input  wire logic                    cke,
  input  wire logic                    cs_n,
  input  wire logic [sr_pkg::CA_W-1:0] cmd_addr,
  output logic                         self_refresh_active,
  output logic                         internal_clk_en,
  output logic                         internal_refresh,
  output logic [NUM_BANKS-1:0]         refresh_bank_en,
  output logic                         exit_busy,
  output logic [7:0]                   bank_mask_state
);
  localparam int TW = sr_pkg::TIMER_W;
  localparam logic [TW-1:0] REF_RELOAD =
    TW'(sr_pkg::REFRESH_INTERVAL_CYC - 1);
  localparam logic [TW-1:0] EXIT_RELOAD =
    TW'(sr_pkg::SR_EXIT_INTERVAL_CYC - 1);

  generate
    if (NUM_BANKS < 1 || NUM_BANKS > 8) begin : g_bad_banks
      $error("NUM_BANKS must lie between 1 and 8");
    end
    if (sr_pkg::REFRESH_INTERVAL_CYC >= (1 << TW)) begin : g_bad_timer
      $error("Refresh interval does not fit the timer");
    end
  endgenerate

  function automatic logic sr_entry(input logic             en,
                                    input logic             sel_n,
                                    input logic [2:0]       ca);
    sr_entry = !en && !sel_n && (ca == sr_pkg::SR_ENTRY_CA);
  endfunction : sr_entry

  sr_pkg::sr_state_t state_reg;
  sr_pkg::sr_state_t state_next;
  logic              mrw_pending_reg;
  logic [5:0]        ma_lo_reg;
  logic [7:0]        bank_mask_reg;
  logic              ref_load;
  logic              ref_done;
  logic [TW-1:0]     ref_load_val;
  logic              exit_load;
  logic              exit_done;
  logic [7:0]        mr_addr;
  logic              entry_now;

  assign entry_now = (state_reg == sr_pkg::ST_IDLE ||
                      state_reg == sr_pkg::ST_EXIT) &&
                     sr_entry(cke, cs_n, cmd_addr[2:0]);
  assign mr_addr = {cmd_addr[sr_pkg::MA_HI_POS +: 2], ma_lo_reg};

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sr_pkg::ST_IDLE: begin
        if (entry_now) begin
          state_next = sr_pkg::ST_SELF_REF;
        end
      end
      sr_pkg::ST_SELF_REF: begin
        if (cke) begin
          state_next = sr_pkg::ST_EXIT;
        end
      end
      sr_pkg::ST_EXIT: begin
        if (!cke) begin
          state_next = sr_pkg::ST_SELF_REF;
        end else if (exit_done) begin
          state_next = sr_pkg::ST_IDLE;
        end
      end
      default: state_next = sr_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= sr_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Exit interval starts on the edge that first sees enable high
  assign exit_load = (state_reg == sr_pkg::ST_SELF_REF) && cke;
  // First internal refresh fires on entry, then on the period timer
  assign ref_load  = (state_reg != sr_pkg::ST_SELF_REF) ||
                     ref_done;
  // Outside self refresh the timer is held empty, so entry finds it done
  assign ref_load_val = (state_reg == sr_pkg::ST_SELF_REF) ? REF_RELOAD :
                                                             '0;

  sr_timer #(.W(TW)) u_ref_timer (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .load     (ref_load),
    .load_val (ref_load_val),
    .done     (ref_done)
  );

  sr_timer #(.W(TW)) u_exit_timer (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .load     (exit_load),
    .load_val (EXIT_RELOAD),
    .done     (exit_done)
  );

  // Mode register writes are decoded only while idle with enable high
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mrw_pending_reg <= 1'b0;
      ma_lo_reg       <= 6'h00;
    end else begin
      mrw_pending_reg <= (state_reg == sr_pkg::ST_IDLE) && cke && !cs_n &&
                         !mrw_pending_reg &&
                         (cmd_addr[3:0] == sr_pkg::MRW_CA);
      ma_lo_reg       <= cmd_addr[sr_pkg::MA_LO_POS +: 6];
    end
  end

  // Segment mask address is accepted but holds nothing on this part
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bank_mask_reg <= sr_pkg::BANK_MASK_RESET;
    end else if (mrw_pending_reg &&
                 mr_addr == sr_pkg::MR_ADDR_BANK_MASK) begin
      bank_mask_reg <= cmd_addr[sr_pkg::OP_POS +: 8];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      self_refresh_active <= 1'b0;
      internal_clk_en     <= 1'b1;
      exit_busy           <= 1'b0;
      bank_mask_state     <= sr_pkg::BANK_MASK_RESET;
    end else begin
      self_refresh_active <= (state_next == sr_pkg::ST_SELF_REF);
      internal_clk_en     <= (state_next != sr_pkg::ST_SELF_REF);
      exit_busy           <= (state_next == sr_pkg::ST_EXIT);
      bank_mask_state     <= bank_mask_reg;
    end
  end

  // A set mask bit blocks refresh of that whole bank
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      internal_refresh <= 1'b0;
      refresh_bank_en  <= '0;
    end else begin
      internal_refresh <= (state_reg == sr_pkg::ST_SELF_REF) &&
                          !cke && ref_done;
      refresh_bank_en  <= ~bank_mask_reg[NUM_BANKS-1:0];
    end
  end

  localparam int A_RES = sr_pkg::MIN_SR_RESIDENCY_CYC + 1;
  localparam int A_XSR = sr_pkg::SR_EXIT_INTERVAL_CYC;

  a_entry_decode: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == sr_pkg::ST_IDLE && !cke && !cs_n &&
     cmd_addr[2:0] == sr_pkg::SR_ENTRY_CA) |=> self_refresh_active)
    else $error("Self refresh entry not taken");
  a_stay_low: assert property (@(posedge clk) disable iff (sys_rst)
    (self_refresh_active && !cke) |=> self_refresh_active)
    else $error("Left self refresh with enable low");
  a_inputs_ignored: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == sr_pkg::ST_SELF_REF) |=> !mrw_pending_reg)
    else $error("Command decoded during self refresh");
  a_clock_gated: assert property (@(posedge clk) disable iff (sys_rst)
    internal_clk_en == !self_refresh_active)
    else $error("Internal clock not gated in self refresh");
  a_first_refresh: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(self_refresh_active) |-> ##[0:A_RES]
      (internal_refresh || !self_refresh_active))
    else $error("No internal refresh within residency");
  a_exit_length: assert property (@(posedge clk) disable iff (sys_rst)
    ($rose(exit_busy) ##1 cke [*2]) |-> exit_busy)
    else $error("Exit interval ended early");
  a_exit_bound: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(exit_busy) |-> ##[1:A_XSR] (!exit_busy))
    else $error("Exit interval overran");
  a_mask_write: assert property (@(posedge clk) disable iff (sys_rst)
    (mrw_pending_reg && mr_addr == sr_pkg::MR_ADDR_BANK_MASK) |=>
      ##1 bank_mask_state == $past(cmd_addr[sr_pkg::OP_POS +: 8], 2))
    else $error("Bank mask write lost");
  a_mask_banks: assert property (@(posedge clk) disable iff (sys_rst)
    internal_refresh |-> refresh_bank_en == ~$past(bank_mask_reg[NUM_BANKS-1:0]))
    else $error("Masked bank refreshed");
  a_seg_ignored: assert property (@(posedge clk) disable iff (sys_rst)
    (mrw_pending_reg && mr_addr == sr_pkg::MR_ADDR_SEG_MASK) |=>
      $stable(bank_mask_reg))
    else $error("Segment write changed bank mask");

  c_enter: cover property (@(posedge clk) disable iff (sys_rst)
    $rose(self_refresh_active));
  c_exit_done: cover property (@(posedge clk) disable iff (sys_rst)
    $fell(exit_busy) && !self_refresh_active);
  c_reentry: cover property (@(posedge clk) disable iff (sys_rst)
    exit_busy ##1 self_refresh_active);
  c_mask_refresh: cover property (@(posedge clk) disable iff (sys_rst)
    internal_refresh && refresh_bank_en != '1);
endmodule : dram_refresh_self_refresh

// ---- sim/sr_host.sv ----
// Controller model that drives the command pins of the self refresh block
`timescale 1ns/1ns
module sr_host (
  input  wire logic clk,
  output logic       cke,
  output logic       cs_n,
  output logic [9:0] cmd_addr
);
  // Refresh credit since the last exit, in eighths of an all-bank refresh
  int ref_units = 0;
  // Cycles spent parked in self refresh
  int sr_cycles = 0;
  initial begin
    cke = 1'h1;
    cs_n = 1'h1;
    cmd_addr = 10'h3FF;
  end
  // Refreshes still owed in a window that held sr_cycles of self refresh
  function automatic int owed();
    int win;
    win = sr_pkg::REFRESH_WINDOW_MS * sr_pkg::CLK_MHZ * 1000;
    return sr_pkg::REFRESH_COUNT -
      (sr_pkg::REFRESH_COUNT * sr_cycles + win - 1) / win;
  endfunction : owed
  // No-op with the enable held high
  task automatic nop(input int n);
    repeat (n) begin
      @(posedge clk);
      cke <= 1'h1;
      cs_n <= 1'h0;
      cmd_addr <= 10'h3FF;
    end
  endtask : nop
  // Mode register write over two rising edges
  task automatic mode_register_write_cmd(input logic [7:0] addr, input logic [7:0] op);
    @(posedge clk);
    cs_n <= 1'h0;
    cmd_addr <= {addr[5:0], 4'h0};
    @(posedge clk);
    cmd_addr <= {op, addr[7:6]};
  endtask : mode_register_write_cmd
  // Model never opens a row, so all banks are idle here
  task automatic enter();
    nop(1);
    @(posedge clk);
    cke <= 1'h0;
    cs_n <= 1'h0;
    cmd_addr <= 10'h004;
    @(posedge clk);
    cmd_addr <= 10'h3FF;
  endtask : enter
  // Pins other than the enable change every cycle while parked
  task automatic junk();
    @(posedge clk);
    cke <= 1'h0;
    cs_n <= cmd_addr[0];
    cmd_addr <= cmd_addr + 10'h001;
    sr_cycles++;
  endtask : junk
  // Clock keeps running, so it is stable well before the enable rises
  task automatic leave();
    @(posedge clk);
    cke <= 1'h1;
    cs_n <= 1'h0;
    cmd_addr <= 10'h3FF;
    ref_units = 0;
  endtask : leave
  task automatic refresh();
    @(posedge clk);
    cs_n <= 1'h0;
    cmd_addr <= 10'h00C;
    ref_units += 8;
    nop(10);
  endtask : refresh
endmodule : sr_host

// ---- sim/dram_refresh_self_refresh_tb.sv ----
// Self-checking bench for the self refresh block
`timescale 1ns/1ns
module dram_refresh_self_refresh_tb;
  logic        clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic        cke;
  logic        cs_n;
  logic [9:0]  cmd_addr;
  logic        self_refresh_active;
  logic        internal_clk_en;
  logic        internal_refresh;
  logic [3:0]  refresh_bank_en;
  logic        exit_busy;
  logic [7:0]  bank_mask_state;
  int          num_errors = 0;
  int          n_tests = 0;
  int unsigned seed = 55;
  logic [7:0]  exp_mask = 8'h00;
  int          pulses;
  int          busy;
  int          ref_at[$];
  always #5 clk = ~clk;
  sr_host host_u (.clk, .cke, .cs_n, .cmd_addr);
  dram_refresh_self_refresh dut_u (.clk, .sys_rst, .cke, .cs_n, .cmd_addr,
    .self_refresh_active, .internal_clk_en, .internal_refresh,
    .refresh_bank_en, .exit_busy, .bank_mask_state);
  function automatic int unsigned xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    n_tests++;
    if (seen !== want) begin
      num_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask : chk
  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out
  // Leave self refresh and count the cycles that show the exit interval
  task automatic timed_exit();
    host_u.leave();
    busy = 0;
    repeat (20) begin
      host_u.nop(1);
      #1;
      busy += exit_busy;
    end
    chk(busy, sr_pkg::SR_EXIT_INTERVAL_CYC);
    chk(self_refresh_active, 1'h0);
    chk(internal_clk_en, 1'h1);
  endtask : timed_exit
  initial begin
    #100000;
    num_errors++;
    close_out();
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'h0;
    host_u.nop(2);
    #1;
    chk(self_refresh_active, 1'h0);
    chk(internal_clk_en, 1'h1);
    chk(exit_busy, 1'h0);
    chk(internal_refresh, 1'h0);
    chk(bank_mask_state, 8'h00);
    chk(refresh_bank_en, 4'hF);
    // Two bank mask writes, then a segment mask write that must not land
    for (int i = 0; i < 3; i++) begin
      logic [7:0] v;
      v = 8'(xorshift());
      host_u.mode_register_write_cmd((i == 2) ? 8'h11 : 8'h10, v);
      if (i < 2) exp_mask = v;
      host_u.nop(4);
      #1;
      chk(bank_mask_state, exp_mask);
      chk(refresh_bank_en, 4'(~exp_mask[3:0]));
    end
    host_u.enter();
    pulses = 0;
    for (int k = 0; k < 790; k++) begin
      host_u.junk();
      #1;
      pulses += internal_refresh;
      chk(self_refresh_active, 1'h1);
      chk(internal_clk_en, 1'h0);
      if (internal_refresh === 1'h1) begin
        ref_at.push_back(k);
        chk(refresh_bank_en, 4'(~exp_mask[3:0]));
      end
    end
    chk(pulses, 1 + 789 / sr_pkg::REFRESH_INTERVAL_CYC);
    chk(ref_at.size(), 2);
    if (ref_at.size() == 2) begin
      chk(ref_at[0] <= sr_pkg::MIN_SR_RESIDENCY_CYC, 1'h1);
      chk(ref_at[1] - ref_at[0], sr_pkg::REFRESH_INTERVAL_CYC);
    end
    chk(bank_mask_state, exp_mask);
    timed_exit();
    host_u.refresh();
    #1;
    chk(self_refresh_active, 1'h0);
    chk(host_u.ref_units, 8);
    // Re-entry part way through the exit interval
    host_u.enter();
    repeat (3) host_u.junk();
    host_u.leave();
    host_u.nop(3);
    #1;
    chk(exit_busy, 1'h1);
    repeat (2) host_u.junk();
    #1;
    chk(self_refresh_active, 1'h1);
    chk(exit_busy, 1'h0);
    host_u.junk();
    timed_exit();
    // Under two refresh intervals spent parked in this window
    chk(host_u.owed(), sr_pkg::REFRESH_COUNT - 2);
    close_out();
  end
endmodule : dram_refresh_self_refresh_tb
